// ### inc/rwk_defines.vh
/*
 * Register indices, field positions and reset values of the
 * wake-up / kickstart power-on block.
 * Assumes byte address = index * 4 on a 32-bit AXI4-Lite bus.
 */
`ifndef RWK_DEFINES_VH
`define RWK_DEFINES_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define RWK_IDX_SEC_ALARM   8'h01
`define RWK_IDX_MIN_ALARM   8'h03
`define RWK_IDX_HOUR_ALARM  8'h05
`define RWK_IDX_CTRL_A      8'h0A
`define RWK_IDX_CTRL_B      8'h0B
`define RWK_IDX_DATE_ALARM  8'h49
`define RWK_IDX_EVT_FLAGS   8'h4A
`define RWK_IDX_EVT_ENABLES 8'h4B
`define RWK_IDX_KICK_SEL    8'h50
`define RWK_IDX_KICK_WIDTH  8'h51
`define RWK_IDX_INT_STATUS  8'h52
`define RWK_IDX_INT_MASK    8'h53

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RWK_BIT_KICK        0
`define RWK_BIT_WAKE        1
`define RWK_BIT_PWR_UP      2
`define RWK_BIT_POWER_OFF   7
`define RWK_DV_HI           6
`define RWK_DV_LO           5
`define RWK_DV_RUNNING      2'h1

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define RWK_RST_ZERO        8'h00
`define RWK_RST_CTRL_A      8'h20
`define RWK_RST_ENABLES     8'h80
`define RWK_RST_KICK_WIDTH  8'h04
`define RWK_RESP_OKAY       2'h0
`define RWK_RESP_SLVERR     2'h2
`define RWK_NUM_SRC         4

`endif

// ### hdl/rwk_power_on.v
/*
 * Battery-backed power-on control: date/time wake-up and pin kickstart
 * drive an open-drain power-on request and the RTC interrupt.
 * Assumes current time bytes come from the RTC counter on core_clk,
 * kick pins and vcc_present are asynchronous, registers via AXI4-Lite.
 */
`timescale 1ns/10ps
`include "rwk_defines.vh"

// Notes on behaviour
// - On battery only, requests need oscillator running and divider select 01X.
// - Wake-up enable bit in the 0x4B register turns date/time wake-up on or off.
// - Kickstart enable bit in the same register gates kickstart likewise.
// - Wake-up compares date, hours, minutes, seconds against the four alarm bytes.
// - Ordinary alarm interrupt enable has no effect on wake-up.
// - Full date/time match with wake-up enabled pulls the request low.
// - Wake-up match sets the wake-up flag at 0x4A.
// - Kickstart enable gates both kickstart request and its interrupt.
// - Four kickstart sources, each with its own select bit, 1 enables.
// - Enabled source low for minimum width pulls the request low.
// - Qualified kickstart sets the kickstart flag at 0x4A.
// - Successful power-on clears power-off bit; request held while it is 0.
// - Software writes 1 to power-off bit; request is then released.
// - Flags clear by writing zeroes; interrupt drops when nothing pending.
// - With power present, a set flag with its enable raises the interrupt.
module rwk_power_on #(
  parameter ADDR_W = 12,
  parameter OSC_DIV = 3052
) (
  input wire core_clk,
  input wire rst_b,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] cur_date,
  input wire [7:0] cur_hours,
  input wire [7:0] cur_minutes,
  input wire [7:0] cur_seconds,
  input wire osc_running,
  input wire vcc_present,
  input wire kbc_port_kick_pin,
  input wire uart_a_ring_in_n,
  input wire uart_b_ring_in_n,
  input wire infrared_receive_in,
  input wire other_rtc_irq,
  output wire power_on_request_n_o,
  output wire power_on_request_n_oe,
  output wire rtc_irq
);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg [7:0] sec_alarm_q;
  reg [7:0] min_alarm_q;
  reg [7:0] hour_alarm_q;
  reg [7:0] date_alarm_q;
  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg [7:0] enables_q;
  reg wakeup_flag_q;
  reg kickstart_flag_q;
  reg [`RWK_NUM_SRC-1:0] kick_sel_q;
  reg [7:0] kick_width_q;
  reg [2:0] int_status_q;
  reg [2:0] int_mask_q;

  wire wakeup_enable = enables_q[`RWK_BIT_WAKE];
  wire kickstart_enable = enables_q[`RWK_BIT_KICK];
  wire power_off_control = enables_q[`RWK_BIT_POWER_OFF];

  // --------------------------------------------------------------
  // Main power detect, three-stage synchroniser
  // --------------------------------------------------------------
  reg vcc_s1_q;
  reg vcc_s2_q;
  reg vcc_s3_q;
  reg vcc_ok_q;
  reg vcc_ok_prev_q;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      vcc_s1_q <= 1'b0;
      vcc_s2_q <= 1'b0;
      vcc_s3_q <= 1'b0;
      vcc_ok_q <= 1'b0;
      vcc_ok_prev_q <= 1'b0;
    end else begin
      vcc_s1_q <= vcc_present;
      vcc_s2_q <= vcc_s1_q;
      vcc_s3_q <= vcc_s2_q;
      if (vcc_s2_q == vcc_s3_q) begin
        vcc_ok_q <= vcc_s3_q;
      end
      vcc_ok_prev_q <= vcc_ok_q;
    end
  end

  // --------------------------------------------------------------
  // Oscillator tick divider
  // --------------------------------------------------------------
  localparam integer OSC_LAST = OSC_DIV - 1;
  wire [31:0] osc_last_w = OSC_LAST;
  reg [15:0] div_cnt_q;
  wire osc_tick = (div_cnt_q == osc_last_w[15:0]);

  always @(posedge core_clk) begin
    if (!rst_b || osc_tick || !osc_running) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Arming: battery mode needs a running countdown chain
  // --------------------------------------------------------------
  wire dv_ok = osc_running &&
               (ctrl_a_q[`RWK_DV_HI:`RWK_DV_LO] == `RWK_DV_RUNNING);
  wire armed = vcc_ok_q || dv_ok;

  // --------------------------------------------------------------
  // Wake-up compare
  // --------------------------------------------------------------
  reg match_q;
  wire match = (cur_date == date_alarm_q) && (cur_hours == hour_alarm_q) &&
               (cur_minutes == min_alarm_q) && (cur_seconds == sec_alarm_q);
  // Alarm interrupt enable in control B deliberately not consulted
  wire wake_evt = match && !match_q && wakeup_enable && armed;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match;
    end
  end

  // --------------------------------------------------------------
  // Kickstart sources: sync, stable level, low-width qualifier
  // --------------------------------------------------------------
  wire [`RWK_NUM_SRC-1:0] src_pin = {infrared_receive_in, uart_b_ring_in_n,
                                     uart_a_ring_in_n, kbc_port_kick_pin};
  wire [`RWK_NUM_SRC-1:0] src_hit;

  genvar g;
  generate
    for (g = 0; g < `RWK_NUM_SRC; g = g + 1) begin : g_src
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      reg done_q;
      reg [7:0] cnt_q;
      always @(posedge core_clk) begin
        if (!rst_b) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
          done_q <= 1'b0;
          cnt_q <= `RWK_RST_ZERO;
        end else begin
          s1_q <= src_pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
          if (lvl_q) begin
            cnt_q <= `RWK_RST_ZERO;
            done_q <= 1'b0;
          end else begin
            if (osc_tick && cnt_q != kick_width_q) begin
              cnt_q <= cnt_q + 8'h01;
            end
            if (src_hit[g]) begin
              done_q <= 1'b1;
            end
          end
        end
      end
      // One hit per low period, once the low has lasted the width
      assign src_hit[g] = !lvl_q && !done_q && (cnt_q == kick_width_q);
    end
  endgenerate

  wire kick_evt = kickstart_enable && armed &&
                  (|(src_hit & kick_sel_q));

  // --------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------
  reg aw_full_q;
  reg w_full_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;

  wire aw_have = aw_full_q || s_axi_awvalid;
  wire w_have = w_full_q || s_axi_wvalid;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_full_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_full_q ? w_strb_q : s_axi_wstrb;
  wire [7:0] wr_idx = wr_addr[9:2];
  wire [7:0] wb = wr_data[7:0];
  wire wr_en = wr_go && wr_strb[0];

  reg wr_hit;
  always @* begin
    case (wr_idx)
      `RWK_IDX_SEC_ALARM, `RWK_IDX_MIN_ALARM, `RWK_IDX_HOUR_ALARM,
      `RWK_IDX_CTRL_A, `RWK_IDX_CTRL_B, `RWK_IDX_DATE_ALARM,
      `RWK_IDX_EVT_FLAGS, `RWK_IDX_EVT_ENABLES, `RWK_IDX_KICK_SEL,
      `RWK_IDX_KICK_WIDTH, `RWK_IDX_INT_STATUS, `RWK_IDX_INT_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RWK_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RWK_RESP_OKAY : `RWK_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_full_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_full_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Register storage and hardware events
  // --------------------------------------------------------------
  wire pwr_up_evt = vcc_ok_q && !vcc_ok_prev_q && !power_off_control;
  wire [2:0] evt_vec = {pwr_up_evt, wake_evt, kick_evt};
  wire is_flags_wr = wr_en && (wr_idx == `RWK_IDX_EVT_FLAGS);
  wire is_stat_wr = wr_en && (wr_idx == `RWK_IDX_INT_STATUS);
  wire is_enab_wr = wr_en && (wr_idx == `RWK_IDX_EVT_ENABLES);
  // A request pending at power rise, or any armed wake-up or kickstart event, holds the bit at 0
  wire clr_power_off = wake_evt || kick_evt || pwr_up_evt;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      sec_alarm_q <= `RWK_RST_ZERO;
      min_alarm_q <= `RWK_RST_ZERO;
      hour_alarm_q <= `RWK_RST_ZERO;
      date_alarm_q <= `RWK_RST_ZERO;
      ctrl_a_q <= `RWK_RST_CTRL_A;
      ctrl_b_q <= `RWK_RST_ZERO;
      enables_q <= `RWK_RST_ENABLES;
      wakeup_flag_q <= 1'b0;
      kickstart_flag_q <= 1'b0;
      kick_sel_q <= {`RWK_NUM_SRC{1'b0}};
      kick_width_q <= `RWK_RST_KICK_WIDTH;
      int_status_q <= 3'h0;
      int_mask_q <= 3'h0;
    end else begin
      if (wr_en) begin
        case (wr_idx)
          `RWK_IDX_SEC_ALARM: sec_alarm_q <= wb;
          `RWK_IDX_MIN_ALARM: min_alarm_q <= wb;
          `RWK_IDX_HOUR_ALARM: hour_alarm_q <= wb;
          `RWK_IDX_DATE_ALARM: date_alarm_q <= wb;
          `RWK_IDX_CTRL_A: ctrl_a_q <= wb;
          `RWK_IDX_CTRL_B: ctrl_b_q <= wb;
          `RWK_IDX_KICK_SEL: kick_sel_q <= wb[`RWK_NUM_SRC-1:0];
          `RWK_IDX_KICK_WIDTH: kick_width_q <= wb;
          `RWK_IDX_INT_MASK: int_mask_q <= wb[2:0];
          default: ;
        endcase
      end
      // Enables; event clear of the power-off bit wins over a write
      if (is_enab_wr) begin
        enables_q <= wb;
      end
      if (clr_power_off) begin
        enables_q[`RWK_BIT_POWER_OFF] <= 1'b0;
      end
      // Flags: write 0 clears, write 1 keeps, set wins
      wakeup_flag_q <= wake_evt ||
                       (wakeup_flag_q && !(is_flags_wr && !wb[`RWK_BIT_WAKE]));
      kickstart_flag_q <= kick_evt ||
                          (kickstart_flag_q && !(is_flags_wr && !wb[`RWK_BIT_KICK]));
      // Sticky status, write 1 clears, set wins
      int_status_q <= evt_vec | (int_status_q & ~(is_stat_wr ? wb[2:0] : 3'h0));
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  reg [7:0] rd_byte;
  reg rd_hit;

  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `RWK_IDX_SEC_ALARM: rd_byte = sec_alarm_q;
      `RWK_IDX_MIN_ALARM: rd_byte = min_alarm_q;
      `RWK_IDX_HOUR_ALARM: rd_byte = hour_alarm_q;
      `RWK_IDX_DATE_ALARM: rd_byte = date_alarm_q;
      `RWK_IDX_CTRL_A: rd_byte = ctrl_a_q;
      `RWK_IDX_CTRL_B: rd_byte = ctrl_b_q;
      `RWK_IDX_EVT_FLAGS: rd_byte = {6'h00, wakeup_flag_q, kickstart_flag_q};
      `RWK_IDX_EVT_ENABLES: rd_byte = enables_q;
      `RWK_IDX_KICK_SEL: rd_byte = {4'h0, kick_sel_q};
      `RWK_IDX_KICK_WIDTH: rd_byte = kick_width_q;
      `RWK_IDX_INT_STATUS: rd_byte = {5'h00, int_status_q};
      `RWK_IDX_INT_MASK: rd_byte = {5'h00, int_mask_q};
      default: begin
        rd_byte = `RWK_RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RWK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `RWK_RESP_OKAY : `RWK_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign power_on_request_n_o = 1'b0;
  assign power_on_request_n_oe = !power_off_control;

  wire flag_irq = (wakeup_flag_q && wakeup_enable) ||
                  (kickstart_flag_q && kickstart_enable);
  assign rtc_irq = vcc_ok_q &&
                   (flag_irq || other_rtc_irq || (|(int_status_q & int_mask_q)));

endmodule // rwk_power_on

// ### testbench/rwk_power_on_monitor.sv
/* Port assertions for the wake-up / kickstart power-on block.
   Assumes one core_clk domain and binding onto rwk_power_on. */
`timescale 1ns/10ps
`include "rwk_defines.vh"
module rwk_power_on_monitor #(
  parameter ADDR_W = 12
) (
  input wire core_clk,
  input wire rst_b,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire vcc_present,
  input wire other_rtc_irq,
  input wire power_on_request_n_o,
  input wire power_on_request_n_oe,
  input wire rtc_irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  sequence s_off_write;
    wr_take && s_axi_awaddr[9:2] == `RWK_IDX_EVT_ENABLES && s_axi_wstrb[0] && s_axi_wdata[7];
  endsequence
  sequence s_no_vcc;
    !vcc_present [*5];
  endsequence
  property p_od_data; power_on_request_n_o == 1'h0; endproperty
  a_od_data: assert property (p_od_data) else $error("request data not low");
  property p_oe_release; s_off_write |-> ##[1:2] !power_on_request_n_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("request not released");
  property p_oe_hold;
    power_on_request_n_oe && !wr_take && !s_axi_bvalid |=> power_on_request_n_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("request dropped");
  property p_wr_ans; wr_take |=> s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  property p_refuse; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_refuse: assert property (p_refuse) else $error("read taken while busy");
  property p_irq_novcc; s_no_vcc |-> !rtc_irq; endproperty
  a_irq_novcc: assert property (p_irq_novcc) else $error("interrupt without power");
  property p_irq_other; vcc_present [*5] ##0 other_rtc_irq |-> rtc_irq; endproperty
  a_irq_other: assert property (p_irq_other) else $error("other source lost");
endmodule // rwk_power_on_monitor
bind rwk_power_on rwk_power_on_monitor #(.ADDR_W(ADDR_W)) u_mon (.core_clk, .rst_b,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .vcc_present, .other_rtc_irq, .power_on_request_n_o, .power_on_request_n_oe,
  .rtc_irq);

// ### testbench/rwk_psu_model.sv
/* Main power supply model: follows the pulled-up request line.
   Assumes the line level is resolved by the bench. */
`timescale 1ns/10ps
module rwk_psu_model (
  input wire core_clk,
  input wire pwr_line_n,
  input wire slow,
  output logic vcc_on
);
  int cnt = 0;
  initial vcc_on = 1'h0;
  // Low line turns supply on, released line turns it off
  always @(posedge core_clk) begin
    if (vcc_on == pwr_line_n) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 20 : 2)) begin
        vcc_on <= !pwr_line_n;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule // rwk_psu_model

// ### testbench/tb_top.sv
/* Self-checking bench of the power-on block over AXI4-Lite.
   Assumes the supply model and the bound port monitor. */
`timescale 1ns/10ps
`include "rwk_defines.vh"
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  logic core_clk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, osc = 1'h1, other = 1'h0, slow = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rd_v;
  logic [7:0] cur_d = 8'h01, cur_h = 8'h00, cur_m = 8'h00, cur_s = 8'h00, a_s, a_m, a_h, a_d;
  logic [3:0] kp = 4'hF;
  logic [1:0] rsp;
  logic [7:0] ri [5] = '{8'h0A, 8'h4B, 8'h51, 8'h4A, 8'h52};
  logic [7:0] rv [5] = '{8'h20, 8'h80, 8'h04, 8'h00, 8'h00};
  logic [7:0] cv [5] = '{8'h00, 8'h40, 8'h60, 8'h30, 8'h20};
  wire awready, wready, bvalid, arready, rvalid, vcc, req_o, req_oe, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire pwr_line = req_oe ? req_o : 1'h1;
  int n_fail = 0, compares = 0, cyc = 0;
  rwk_power_on #(.ADDR_W(12), .OSC_DIV(4)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cur_date(cur_d), .cur_hours(cur_h),
    .cur_minutes(cur_m), .cur_seconds(cur_s), .osc_running(osc), .vcc_present(vcc),
    .kbc_port_kick_pin(kp[0]), .uart_a_ring_in_n(kp[1]), .uart_b_ring_in_n(kp[2]),
    .infrared_receive_in(kp[3]), .other_rtc_irq(other), .power_on_request_n_o(req_o),
    .power_on_request_n_oe(req_oe), .rtc_irq(irq));
  rwk_psu_model psu (.core_clk(core_clk), .pwr_line_n(pwr_line), .slow(slow), .vcc_on(vcc));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task close_out;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    rsp = bresp;
  endtask
  task rd(input logic [7:0] idx);
    @(posedge core_clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd_v = rdata;
    rsp = rresp;
  endtask
  task irq_is(input logic e);
    @(posedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task kick(input int src, input int len, input logic e);
    @(posedge core_clk);
    kp[src] <= 1'h0;
    repeat (len) @(posedge core_clk);
    kp[src] <= 1'h1;
    repeat (12) @(posedge core_clk);
    rd(8'h4A);
    chk(rd_v & 32'h1, {31'h0, e});
    chk({31'h0, req_oe}, {31'h0, e});
    rd(8'h4B);
    chk(rd_v & 32'h80, e ? 32'h0 : 32'h80);
  endtask
  task pwr_down;
    wr(8'h4B, 8'h80);
    wr(8'h4A, 8'h00);
    wr(8'h52, 8'h07);
    while (vcc !== 1'h0) @(posedge core_clk);
    repeat (5) @(posedge core_clk);
    chk({31'h0, req_oe}, 32'h0);
  endtask
  function automatic logic gate_ok(input logic [7:0] c, input logic o);
    return c[6:5] == `RWK_DV_RUNNING && o;
  endfunction
  initial begin
    void'($urandom(49328));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      rd(ri[i]);
      chk(rd_v, {24'h0, rv[i]});
    end
    rd(8'h3F);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h3F, 8'hFF);
    chk({30'h0, rsp}, 32'h2);
    $display("reset and map test done");
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      wr(8'h51, 8'($urandom_range(3, 0)));
      wr(8'h50, 8'h01 << i);
      wr(8'h4B, 8'h81);
      kick((i + 1) % 4, 40, 1'h0);
      kick(i, 40, 1'h1);
      while (vcc !== 1'h1) @(posedge core_clk);
      repeat (5) @(posedge core_clk);
      irq_is(1'h1);
      wr(8'h4A, 8'h00);
      irq_is(1'h0);
      other <= 1'h1;
      repeat (6) @(posedge core_clk);
      other <= 1'h0;
      wr(8'h53, 8'h04);
      irq_is(1'h1);
      rd(8'h52);
      chk(rd_v & 32'h4, 32'h4);
      wr(8'h52, 8'h04);
      irq_is(1'h0);
      wr(8'h53, 8'h00);
      pwr_down;
    end
    $display("kick source test done");
    wr(8'h50, 8'h0F);
    kick(2, 40, 1'h0);
    wr(8'h4B, 8'h81);
    wr(8'h51, 8'h08);
    kick(0, 12, 1'h0);
    kick(0, 60, 1'h1);
    pwr_down;
    wr(8'h51, 8'h01);
    for (int i = 0; i < 6; i++) begin
      osc <= i < 5;
      wr(8'h0A, i < 5 ? cv[i] : 8'h20);
      wr(8'h4B, 8'h81);
      kick(3, 40, gate_ok(i < 5 ? cv[i] : 8'h20, i < 5));
      pwr_down;
    end
    osc <= 1'h1;
    wr(8'h0A, 8'h20);
    $display("gating test done");
    a_s = 8'($urandom);
    a_m = 8'($urandom);
    a_h = 8'($urandom);
    a_d = 8'($urandom);
    wr(8'h01, a_s);
    wr(8'h03, a_m);
    wr(8'h05, a_h);
    wr(8'h49, a_d);
    wr(8'h0B, 8'($urandom));
    for (int m = 0; m < 3; m++) begin
      cur_s <= a_s ^ 8'h80;
      wr(8'h4B, m > 0 ? 8'h82 : 8'h80);
      cur_s <= m == 1 ? a_s + 8'h01 : a_s;
      cur_m <= a_m;
      cur_h <= a_h;
      cur_d <= a_d;
      repeat (4) @(posedge core_clk);
      cur_s <= a_s ^ 8'h80;
      rd(8'h4A);
      chk(rd_v & 32'h2, m == 2 ? 32'h2 : 32'h0);
      chk({31'h0, req_oe}, {31'h0, m == 2});
      pwr_down;
    end
    $display("wake test done");
    close_out;
  end
endmodule // tb_top
